// ===== adcc_consts.svh
// Offsets, field positions, reset values and counts of the converter control block
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH

// ============================================================
// Register byte offsets (haddr[7:0])
`define ADCC_OFF_CTRL 8'h00
`define ADCC_OFF_SC 8'h04
`define ADCC_OFF_RH 8'h08
`define ADCC_OFF_RL 8'h0c

// ============================================================
// Converter control field positions
`define ADCC_CTRL_PU 7
`define ADCC_CTRL_DJM 6
`define ADCC_CTRL_EIGHT_BIT_RESOLUTION 5
`define ADCC_CTRL_SGN 4
`define ADCC_CTRL_PRS_MSB 3
`define ADCC_CTRL_PRS_LSB 0

// ============================================================
// Status and control field positions
`define ADCC_SC_FLAG 7
`define ADCC_SC_IE 6

// ============================================================
// Reset values and counts
`define ADCC_CTRL_RST 8'h00
`define ADCC_RES_RST 8'h00
`define ADCC_CONV_TICKS 10
`define ADCC_HSIZE_WORD 3'h2

`endif

// ===== adcc_pkg.sv
// Types shared by the converter control block
package adcc_pkg;

  // ============================================================
  // Sequencer state
  typedef enum logic {SEQ_IDLE, SEQ_CONV} adcc_seq_mode_t;

  typedef struct packed {
    adcc_seq_mode_t mode;
    logic [4:0] div;
    logic [7:0] ticks;
  } adcc_seq_state_t;

  // ============================================================
  // Register select and top state
  typedef enum logic [2:0] {SEL_NONE, SEL_CTRL, SEL_SC, SEL_RH, SEL_RL} adcc_sel_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic ie;
    logic flag;
    logic [7:0] res_h;
    logic [7:0] res_l;
    logic ph_valid;
    logic ph_wr;
    adcc_sel_t ph_sel;
    logic [7:0] rdata;
  } adcc_top_state_t;

endpackage : adcc_pkg

// ===== adcc_seq.sv
// Conversion clock prescaler and conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.svh"

module adcc_seq import adcc_pkg::*; #(
  parameter int CONV_TICKS = `ADCC_CONV_TICKS
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic [3:0] prescale,
  // Status
  output logic busy,
  output logic conv_clk_tick,
  output logic done
);

  adcc_seq_state_t s_q, s_d;
  logic done_raw;

  // Last count of the divider: factor (p+1)*2 means 2p+1
  function automatic logic [4:0] div_limit(input logic [3:0] p);
    div_limit = {p, 1'b1};
  endfunction : div_limit

  // ============================================================
  // Next state
  always_comb begin
    s_d = s_q;
    conv_clk_tick = 1'b0;
    done_raw = 1'b0;
    unique case (s_q.mode)
      SEQ_IDLE: begin
      end
      SEQ_CONV: begin
        if (s_q.div == div_limit(prescale)) begin
          s_d.div = 5'h00;
          conv_clk_tick = 1'b1;
          if (s_q.ticks == 8'(CONV_TICKS - 1)) begin
            done_raw = 1'b1;
            s_d.mode = SEQ_IDLE;
          end else begin
            s_d.ticks = s_q.ticks + 8'h01;
          end
        end else begin
          s_d.div = s_q.div + 5'h01;
        end
      end
    endcase
    // Restart wins over a finishing conversion; its result is still reported
    if (start) begin
      s_d.mode = SEQ_CONV;
      s_d.div = 5'h00;
      s_d.ticks = 8'h00;
    end
    if (abort) begin
      s_d.mode = SEQ_IDLE;
    end
  end

  // Aborted conversions never report completion
  assign done = done_raw & ~abort;
  assign busy = (s_q.mode == SEQ_CONV);

  // ============================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{mode: SEQ_IDLE, div: 5'h00, ticks: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // Checks
  logic [4:0] gap_q;
  logic seen_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_q <= 5'h00;
      seen_q <= 1'b0;
    end else begin
      gap_q <= conv_clk_tick ? 5'h00 : gap_q + 5'h01;
      seen_q <= (conv_clk_tick | seen_q) & ~start & ~abort & ~done_raw;
    end
  end

  property p_tick_period;
    @(posedge hclk) disable iff (!hresetn)
      conv_clk_tick && seen_q |-> gap_q == div_limit(prescale);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("conversion clock period wrong");

  property p_abort_idle;
    @(posedge hclk) disable iff (!hresetn)
      abort && !start |=> !busy && !done;
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("abort left sequencer running");

endmodule : adcc_seq
`default_nettype wire

// ===== adcc_top.sv
// Converter control, result formatting and AHB-Lite register slave
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.svh"

module adcc_top import adcc_pkg::*; #(
  parameter int CONV_TICKS = `ADCC_CONV_TICKS
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Analog core
  input wire logic [9:0] conv_sample,
  output logic converter_power_on,
  output logic conv_busy,
  output logic conv_clk_tick,
  // Interrupt request
  output logic conv_irq
);

  adcc_top_state_t s_q, s_d;
  logic acc;
  adcc_sel_t addr_sel;
  logic wr_ctrl, wr_sc, rd_res;
  logic seq_start, seq_abort, seq_done;
  logic [15:0] fmt_res;

  // ============================================================
  // Helpers
  function automatic adcc_sel_t decode(input logic [7:0] a);
    unique case (a)
      `ADCC_OFF_CTRL: decode = SEL_CTRL;
      `ADCC_OFF_SC: decode = SEL_SC;
      `ADCC_OFF_RH: decode = SEL_RH;
      `ADCC_OFF_RL: decode = SEL_RL;
      default: decode = SEL_NONE;
    endcase
  endfunction : decode

  // Builds {result_high, result_low} from the raw sample and the mode bits
  function automatic logic [15:0] format_result(input logic [9:0] raw, input logic eight_bit_resolution,
                                                input logic justify_right, input logic signed_result);
    logic [9:0] v;
    v = raw;
    if (eight_bit_resolution) begin
      // resolution bit picks the 8-bit layout
      format_result = {raw[9] ^ (signed_result & ~justify_right), raw[8:2], 8'h00};
    end else if (justify_right) begin
      // justify bit set places the value right justified
      format_result = {6'h00, raw};
    end else begin
      // flipping bit 9 maps 0x000..0x3FF onto 0x200..0x1FF
      v[9] = raw[9] ^ signed_result;
      format_result = {v, 6'h00};
    end
  endfunction : format_result

  // ============================================================
  // Bus decode: address phase taken on hready, writes land in data phase
  assign acc = hsel & htrans[1] & hready;
  assign addr_sel = decode(haddr[7:0]);
  assign wr_ctrl = s_q.ph_valid & s_q.ph_wr & (s_q.ph_sel == SEL_CTRL);
  assign wr_sc = s_q.ph_valid & s_q.ph_wr & (s_q.ph_sel == SEL_SC);
  // Side effect taken at the address phase, so a status read right behind it already shows the flag clear
  assign rd_res = acc & ~hwrite & ((addr_sel == SEL_RH) | (addr_sel == SEL_RL));

  // ============================================================
  // Sequencer control
  // status-control write starts a conversion when powered
  assign seq_start = wr_sc & s_q.ctrl[`ADCC_CTRL_PU];
  assign seq_abort = wr_ctrl | ~s_q.ctrl[`ADCC_CTRL_PU];

  adcc_seq #(
    .CONV_TICKS(CONV_TICKS)
  ) u_seq (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(seq_start),
    .abort(seq_abort),
    .prescale(s_q.ctrl[`ADCC_CTRL_PRS_MSB:`ADCC_CTRL_PRS_LSB]),
    .busy(conv_busy),
    .conv_clk_tick(conv_clk_tick),
    .done(seq_done)
  );

  // Mode bits sampled as the result is loaded
  assign fmt_res = format_result(conv_sample, s_q.ctrl[`ADCC_CTRL_EIGHT_BIT_RESOLUTION], s_q.ctrl[`ADCC_CTRL_DJM],
                                 s_q.ctrl[`ADCC_CTRL_SGN]);

  // ============================================================
  // Next state
  always_comb begin
    s_d = s_q;
    // Address phase capture and read data
    s_d.ph_valid = acc;
    s_d.ph_wr = hwrite;
    s_d.ph_sel = acc ? addr_sel : SEL_NONE;
    if (acc && !hwrite) begin
      unique case (addr_sel)
        SEL_CTRL: s_d.rdata = s_q.ctrl;
        SEL_SC: s_d.rdata = {s_q.flag, s_q.ie, 6'h00};
        SEL_RH: s_d.rdata = s_q.res_h;
        SEL_RL: s_d.rdata = s_q.res_l;
        SEL_NONE: s_d.rdata = 8'h00;
      endcase
    end
    // Write size is not checked; byte lane 0 carries every field
    if (wr_ctrl) begin
      // power bit stored, gates the sequencer
      s_d.ctrl = hwdata[7:0];
    end
    if (wr_sc) begin
      s_d.ie = hwdata[`ADCC_SC_IE];
    end
    if (wr_sc || rd_res) begin
      s_d.flag = 1'b0;
    end
    // flag and results in the same cycle; set wins over clear
    if (seq_done) begin
      s_d.flag = 1'b1;
      s_d.res_h = fmt_res[15:8];
      s_d.res_l = fmt_res[7:0];
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{ctrl: `ADCC_CTRL_RST, ie: 1'b0, flag: 1'b0, res_h: `ADCC_RES_RST, res_l: `ADCC_RES_RST,
               ph_valid: 1'b0, ph_wr: 1'b0, ph_sel: SEL_NONE, rdata: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // Outputs
  // Zero wait states keep the slave simple; every transfer is OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, s_q.rdata};
  assign converter_power_on = s_q.ctrl[`ADCC_CTRL_PU];
  assign conv_irq = s_q.flag & s_q.ie;

  // ============================================================
  // Assertions
  property p_done_irq;
    @(posedge hclk) disable iff (!hresetn)
      seq_done && s_q.ie && !wr_sc |=> conv_irq && s_q.flag;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("no interrupt after conversion end");

  property p_irq_hold;
    @(posedge hclk) disable iff (!hresetn)
      conv_irq && !wr_sc && !rd_res |=> conv_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped while flag set");

  property p_sc_clear;
    @(posedge hclk) disable iff (!hresetn)
      wr_sc && !seq_done |=> !s_q.flag && !conv_irq;
  endproperty
  a_sc_clear: assert property (p_sc_clear) else $error("status write kept flag");

  property p_read_clear;
    @(posedge hclk) disable iff (!hresetn)
      rd_res && !seq_done |=> !s_q.flag;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("result read kept flag");

  property p_ctrl_abort;
    @(posedge hclk) disable iff (!hresetn)
      wr_ctrl |=> !conv_busy ##1 (!conv_busy || $past(seq_start));
  endproperty
  a_ctrl_abort: assert property (p_ctrl_abort) else $error("control write did not abort");

  property p_power_off;
    @(posedge hclk) disable iff (!hresetn)
      !converter_power_on |=> !conv_busy && !seq_done;
  endproperty
  a_power_off: assert property (p_power_off) else $error("converter ran while powered down");

  property p_sc_start;
    @(posedge hclk) disable iff (!hresetn)
      wr_sc && converter_power_on |=> conv_busy;
  endproperty
  a_sc_start: assert property (p_sc_start) else $error("status write did not start");

  property p_eight_bit;
    @(posedge hclk) disable iff (!hresetn)
      seq_done && s_q.ctrl[`ADCC_CTRL_EIGHT_BIT_RESOLUTION] |=>
        s_q.res_l == 8'h00 && {1'b0, s_q.res_h[6:0], 2'b00} == ($past(conv_sample) & 10'h1fc);
  endproperty
  a_eight_bit: assert property (p_eight_bit) else $error("8-bit result misplaced");

  property p_right_unsigned;
    @(posedge hclk) disable iff (!hresetn)
      seq_done && !s_q.ctrl[`ADCC_CTRL_EIGHT_BIT_RESOLUTION] && s_q.ctrl[`ADCC_CTRL_DJM] |=>
        {s_q.res_h, s_q.res_l} == {6'h00, $past(conv_sample)};
  endproperty
  a_right_unsigned: assert property (p_right_unsigned) else $error("right justified result wrong");

  property p_signed_msb;
    @(posedge hclk) disable iff (!hresetn)
      seq_done && s_q.ctrl[`ADCC_CTRL_SGN] && !s_q.ctrl[`ADCC_CTRL_DJM] |=>
        {s_q.res_h[7], 9'h000} != ($past(conv_sample) & 10'h200);
  endproperty
  a_signed_msb: assert property (p_signed_msb) else $error("signed MSB not inverted");

  property p_flag_with_result;
    @(posedge hclk) disable iff (!hresetn)
      $rose(s_q.flag) |-> $past(seq_done) && $past(conv_busy);
  endproperty
  a_flag_with_result: assert property (p_flag_with_result) else $error("flag set without result");

  // Main scenarios
  c_conv_irq: cover property (@(posedge hclk) disable iff (!hresetn) seq_done && s_q.ie);
  c_read_clear: cover property (@(posedge hclk) disable iff (!hresetn) rd_res && s_q.flag);
  c_abort_busy: cover property (@(posedge hclk) disable iff (!hresetn) wr_ctrl && conv_busy);
  c_set_over_clear: cover property (@(posedge hclk) disable iff (!hresetn) seq_done && (wr_sc || rd_res));

endmodule : adcc_top
`default_nettype wire

// ===== adcc_top_tb.sv
// Self-checking bench of the converter control block over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end

module adcc_top_tb;
  import adcc_pkg::*;
  // ============================================================
  // Signals
  localparam int TICKS = 2;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = `ADCC_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [9:0] conv_sample = 10'h0;
  logic converter_power_on;
  logic conv_busy;
  logic conv_clk_tick;
  logic conv_irq;
  int err_count = 0;
  int checks = 0;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;

  adcc_top #(.CONV_TICKS(TICKS)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .conv_sample(conv_sample),
    .converter_power_on(converter_power_on), .conv_busy(conv_busy), .conv_clk_tick(conv_clk_tick),
    .conv_irq(conv_irq));

  // ============================================================
  // Bus tasks; master waits on ready, never on a fixed count
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? wd : 32'h0;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    ahb(1'b1, a, {24'h0, d}, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0, d);
  endtask : rd

  // Expected result pair from mode bits and raw value
  function automatic logic [15:0] fmt(input logic [7:0] c, input logic [9:0] r);
    logic sg;
    sg = c[`ADCC_CTRL_SGN] & ~c[`ADCC_CTRL_DJM];
    if (c[`ADCC_CTRL_EIGHT_BIT_RESOLUTION]) return {r[9] ^ sg, r[8:2], 8'h00};
    if (c[`ADCC_CTRL_DJM]) return {6'h0, r};
    return {r[9] ^ sg, r[8:0], 6'h0};
  endfunction : fmt

  // Configure, start and run one conversion; n busy cycles, t ticks
  task automatic conv(input logic [7:0] c, input logic [9:0] s, input logic [7:0] sc, output int n, output int t);
    @(posedge hclk);
    conv_sample <= s;
    wr(`ADCC_OFF_CTRL, c);
    wr(`ADCC_OFF_SC, sc);
    #1;
    n = 0;
    t = 0;
    while (conv_busy === 1'b1 && n < 5000) begin
      t += (conv_clk_tick === 1'b1);
      @(posedge hclk);
      #1;
      n++;
    end
    // A conversion that never ends counts as a mismatch
    `CHK("conv end", 1'b0, conv_busy)
  endtask : conv

  // ============================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] d;
    `CHK("pwr", 1'b0, converter_power_on)
    `CHK("irq", 1'b0, conv_irq)
    rd(`ADCC_OFF_CTRL, d); `CHK("ctrl rst", {24'h0, `ADCC_CTRL_RST}, d)
    rd(`ADCC_OFF_SC, d); `CHK("sc rst", 2'b00, d[7:6])
    rd(`ADCC_OFF_RH, d); `CHK("rh rst", {24'h0, `ADCC_RES_RST}, d)
    wr(`ADCC_OFF_CTRL, 8'h5a);
    rd(`ADCC_OFF_CTRL, d); `CHK("ctrl rw", 32'h5a, d)
    wr(`ADCC_OFF_RL, 8'hff);
    wr(8'h10, 8'hff);
    rd(`ADCC_OFF_RL, d); `CHK("rl ro", 32'h0, d)
    rd(8'h10, d); `CHK("unmapped", 32'h0, d)
    // Powered down: a start request does nothing
    wr(`ADCC_OFF_SC, 8'h40);
    #1; `CHK("busy off", 1'b0, conv_busy)
    $display("test reset done");
  endtask : t_reset

  task automatic t_formats;
    // prescale 9 keeps the conversion clock at 2 MHz
    logic [7:0] modes [6] = '{8'ha9, 8'hb9, 8'hf9, 8'h89, 8'h99, 8'hd9};
    logic [9:0] raws [3] = '{10'h3ff, 10'h000, 10'h2a5};
    logic [31:0] h, l;
    int n, t;
    foreach (modes[m]) foreach (raws[k]) begin
      conv(modes[m], raws[k], 8'h40, n, t);
      `CHK("irq end", 1'b1, conv_irq)
      rd(`ADCC_OFF_RH, h);
      rd(`ADCC_OFF_RL, l);
      `CHK("res", fmt(modes[m], raws[k]), {h[7:0], l[7:0]})
      `CHK("irq rd", 1'b0, conv_irq)
    end
    $display("test formats done");
  endtask : t_formats

  task automatic t_prescale;
    // only settings from 2 MHz down to 1.25 MHz
    logic [3:0] ps [3] = '{4'h9, 4'hc, 4'hf};
    int n, t;
    foreach (ps[i]) begin
      conv({4'h8, ps[i]}, 10'h155, 8'h00, n, t);
      `CHK("busy len", TICKS * 2 * (ps[i] + 1), n)
      `CHK("ticks", TICKS, t)
    end
    $display("test prescale done");
  endtask : t_prescale

  task automatic t_flag;
    logic [31:0] d;
    int n, t;
    // Enable clear: polling only
    conv(8'h89, 10'h0f0, 8'h00, n, t);
    repeat (3) @(posedge hclk);
    `CHK("irq off", 1'b0, conv_irq)
    rd(`ADCC_OFF_SC, d); `CHK("flag poll", 2'b10, d[7:6])
    rd(`ADCC_OFF_SC, d); `CHK("flag held", 2'b10, d[7:6])
    rd(`ADCC_OFF_RL, d);
    rd(`ADCC_OFF_SC, d); `CHK("rl clr", 2'b00, d[7:6])
    // Status write clears flag, cancels request, restarts
    conv(8'h89, 10'h0f0, 8'h40, n, t);
    repeat (4) @(posedge hclk);
    `CHK("irq hold", 1'b1, conv_irq)
    wr(`ADCC_OFF_SC, 8'h40);
    #1;
    `CHK("irq clr", 1'b0, conv_irq)
    `CHK("restart", 1'b1, conv_busy)
    $display("test flag done");
  endtask : t_flag

  task automatic t_abort;
    logic [31:0] d;
    int n, t;
    conv(8'h89, 10'h3c0, 8'h40, n, t);
    rd(`ADCC_OFF_RH, d);
    conv_sample <= 10'h03f;
    // Control write in mid-conversion
    wr(`ADCC_OFF_SC, 8'h40);
    wr(`ADCC_OFF_CTRL, 8'h89);
    #1; `CHK("ctrl abort", 1'b0, conv_busy)
    repeat (30) @(posedge hclk);
    #1; `CHK("no start", 1'b0, conv_busy)
    rd(`ADCC_OFF_SC, d); `CHK("no flag", 2'b01, d[7:6])
    rd(`ADCC_OFF_RH, d); `CHK("rh kept", 32'hf0, d)
    // Power down in mid-conversion
    wr(`ADCC_OFF_SC, 8'h40);
    wr(`ADCC_OFF_CTRL, 8'h09);
    #1;
    `CHK("pwr abort", 1'b0, conv_busy)
    `CHK("pwr bit", 1'b0, converter_power_on)
    repeat (30) @(posedge hclk);
    `CHK("irq none", 1'b0, conv_irq)
    $display("test abort done");
  endtask : t_abort

  // ============================================================
  // Verdict and run control
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_formats();
    t_prescale();
    t_flag();
    t_abort();
    close_out();
  end

  // Whole run needs under two thousand cycles
  initial begin
    #(25 * 40000);
    err_count++;
    $display("unexpected timeout exp %h got %h", 1'b0, 1'b1);
    close_out();
  end
endmodule : adcc_top_tb
`default_nettype wire
